// ===== design/gtc_gated_timer.sv
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module gtc_gated_timer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       gate_input,
    input  wire logic       external_count_pin,
    input  wire logic       eight_bit_tick,
    input  wire logic       period_tick,
    input  wire logic       watchdog_enable_fuse,
    input  wire logic       watchdog_clear_instr,
    input  wire logic       sleep_mode,
    output logic            irq,
    output logic            wake,
    output logic            vector_req,
    output logic            watchdog_reset
);

    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction

    function automatic logic fall(input logic prev, input logic cur);
        fall = prev & ~cur;
    endfunction

    gtc_pkg::gtc_bus_type      bus;
    gtc_pkg::gtc_gate_cfg_type gcfg_q, gcfg_d;
    gtc_pkg::gtc_sp_type       sp_q, sp_d;

    logic        run_q, run_d, syncb_q, syncb_d;
    logic        ovf_flag_q, ovf_flag_d, gev_flag_q, gev_flag_d;
    logic        ovf_ie_q, ovf_ie_d, gev_ie_q, gev_ie_d;
    logic        peripheral_irq_enable_q, peripheral_irq_enable_d, gie_q, gie_d;
    logic [7:0]  option_q, option_d;
    logic [15:0] count_q, count_d;
    logic        armed_q, armed_d, clk_prev_q;
    logic [7:0]  eight_q, eight_d, per_q, per_d, limit_q, limit_d;
    logic        eight_pulse_q, eight_pulse_d, per_pulse_q, per_pulse_d;
    logic [7:0]  wbase_q, wbase_d, wpre_q, wpre_d, wdog_q, wdog_d;
    logic        wdog_pulse_q, wdog_pulse_d;
    logic        src_prev_q, tff_q, tff_d, gval_q, gval_d;
    logic [7:0]  rdata_d;
    logic        irq_d, wake_d, vec_d, wrst_d;

    logic        src_raw, src_act, gate_ctl, count_en, inc, wdog_on;
    logic        pre_done;
    logic [7:0]  pre_limit;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // Gate path.
    always_comb
    begin
        case (gcfg_q.gate_source_select)
            gtc_pkg::GSRC_PIN:    src_raw = gate_input;
            gtc_pkg::GSRC_EIGHT:  src_raw = eight_pulse_q;
            gtc_pkg::GSRC_PERIOD: src_raw = per_pulse_q;
            gtc_pkg::GSRC_WDOG:   src_raw = wdog_pulse_q;
            default:              src_raw = gate_input;
        endcase
        src_act = gcfg_q.gate_polarity_bit ? src_raw : ~src_raw;
        tff_d = tff_q;
        if (!gcfg_q.gate_toggle_enable)
        begin
            tff_d = 1'b0;
        end
        else if (rise(src_prev_q, src_act))
        begin
            tff_d = ~tff_q;
        end
        gate_ctl = gcfg_q.gate_toggle_enable ? tff_q : src_act;
        // Single-pulse sequencing works on the toggled value too.
        sp_d = sp_q;
        gcfg_d = gcfg_q;
        if (!gcfg_q.gate_single_pulse_enable || !gcfg_q.gate_pulse_go_done)
        begin
            sp_d = gtc_pkg::SP_IDLE;
        end
        else
        begin
            case (sp_q)
                gtc_pkg::SP_IDLE:  sp_d = gate_ctl ? gtc_pkg::SP_IDLE : gtc_pkg::SP_ARMED;
                gtc_pkg::SP_ARMED: sp_d = gate_ctl ? gtc_pkg::SP_COUNT : gtc_pkg::SP_ARMED;
                gtc_pkg::SP_COUNT:
                begin
                    if (!gate_ctl)
                    begin
                        sp_d = gtc_pkg::SP_IDLE;
                        gcfg_d.gate_pulse_go_done = 1'b0;
                    end
                end
                default:           sp_d = gtc_pkg::SP_IDLE;
            endcase
        end
        if (gcfg_q.gate_single_pulse_enable)
        begin
            gval_d = (sp_q == gtc_pkg::SP_COUNT) && gate_ctl;
        end
        else
        begin
            gval_d = gate_ctl;
        end
        if (bus.wr && bus.addr == gtc_pkg::ADDR_GATE_CTRL)
        begin
            gcfg_d.gate_enable_bit          = bus.wdata[gtc_pkg::GEN_POS];
            gcfg_d.gate_polarity_bit        = bus.wdata[gtc_pkg::GPOL_POS];
            gcfg_d.gate_toggle_enable       = bus.wdata[gtc_pkg::GTM_POS];
            gcfg_d.gate_single_pulse_enable = bus.wdata[gtc_pkg::GSPM_POS];
            gcfg_d.gate_pulse_go_done       = bus.wdata[gtc_pkg::GGO_POS]
                                            & bus.wdata[gtc_pkg::GSPM_POS];
            gcfg_d.gate_source_select = gtc_pkg::gtc_gsrc_type'(
                bus.wdata[gtc_pkg::GSEL_LO +: 2]);
        end
    end

    // Eight-bit timer, period timer and watchdog sources.
    always_comb
    begin
        eight_d = eight_q;
        eight_pulse_d = 1'b0;
        if (bus.wr && bus.addr == gtc_pkg::ADDR_EIGHT_COUNT)
        begin
            eight_d = bus.wdata;
        end
        else if (eight_bit_tick)
        begin
            eight_d = eight_q + 8'h01;
            eight_pulse_d = (eight_q == gtc_pkg::BYTE_MAX);
        end
        per_d = per_q;
        per_pulse_d = 1'b0;
        limit_d = limit_q;
        if (bus.wr && bus.addr == gtc_pkg::ADDR_PERIOD_LIMIT)
        begin
            limit_d = bus.wdata;
        end
        if (bus.wr && bus.addr == gtc_pkg::ADDR_PERIOD_COUNT)
        begin
            per_d = bus.wdata;
        end
        else if (period_tick)
        begin
            if (per_q == limit_q)
            begin
                per_d = gtc_pkg::BYTE_ZERO;
                per_pulse_d = 1'b1;
            end
            else
            begin
                per_d = per_q + 8'h01;
            end
        end
        wdog_on = watchdog_enable_fuse || (gcfg_q.gate_enable_bit
                  && gcfg_q.gate_source_select == gtc_pkg::GSRC_WDOG);
        // Prescaler only serves the watchdog when assigned to it.
        pre_limit = option_q[gtc_pkg::PSA_POS]
                  ? 8'(gtc_pkg::PRESC_ONE << option_q[gtc_pkg::PS_LO +: 3])
                  : gtc_pkg::PRESC_ONE;
        wbase_d = wbase_q;
        wpre_d = wpre_q;
        wdog_d = wdog_q;
        wdog_pulse_d = 1'b0;
        pre_done = 1'b0;
        if (!wdog_on || watchdog_clear_instr)
        begin
            wbase_d = gtc_pkg::BYTE_ZERO;
            wpre_d = gtc_pkg::BYTE_ZERO;
            wdog_d = gtc_pkg::BYTE_ZERO;
        end
        else if (wbase_q == gtc_pkg::WDT_BASE_CYC - 8'h01)
        begin
            wbase_d = gtc_pkg::BYTE_ZERO;
            pre_done = (wpre_q >= pre_limit - 8'h01);
            wpre_d = pre_done ? gtc_pkg::BYTE_ZERO : wpre_q + 8'h01;
            if (pre_done)
            begin
                wdog_d = wdog_q + 8'h01;
                wdog_pulse_d = (wdog_q == gtc_pkg::BYTE_MAX);
            end
        end
        else
        begin
            wbase_d = wbase_q + 8'h01;
        end
        wrst_d = wdog_pulse_q && watchdog_enable_fuse && !sleep_mode;
    end

    // Counter, flags and register port.
    always_comb
    begin
        count_en = run_q && (!gcfg_q.gate_enable_bit || gval_q);
        armed_d = armed_q;
        if (!run_q)
        begin
            armed_d = 1'b0;
        end
        else if (fall(clk_prev_q, external_count_pin))
        begin
            armed_d = 1'b1;
        end
        inc = count_en && armed_q && rise(clk_prev_q, external_count_pin)
              && (!sleep_mode || syncb_q);
        count_d = inc ? count_q + 16'h0001 : count_q;
        run_d = run_q;
        syncb_d = syncb_q;
        option_d = option_q;
        ovf_ie_d = ovf_ie_q;
        gev_ie_d = gev_ie_q;
        peripheral_irq_enable_d = peripheral_irq_enable_q;
        gie_d = gie_q;
        ovf_flag_d = ovf_flag_q;
        gev_flag_d = gev_flag_q;
        if (bus.wr)
        begin
            case (bus.addr)
                gtc_pkg::ADDR_COUNTER_CTRL:
                begin
                    run_d = bus.wdata[gtc_pkg::RUN_POS];
                    syncb_d = bus.wdata[gtc_pkg::SYNCB_POS];
                end
                gtc_pkg::ADDR_IRQ_FLAGS:
                begin
                    ovf_flag_d = bus.wdata[gtc_pkg::OVF_POS];
                    gev_flag_d = bus.wdata[gtc_pkg::GEV_POS];
                end
                gtc_pkg::ADDR_IRQ_ENABLE:
                begin
                    ovf_ie_d = bus.wdata[gtc_pkg::OVF_POS];
                    gev_ie_d = bus.wdata[gtc_pkg::GEV_POS];
                    peripheral_irq_enable_d = bus.wdata[gtc_pkg::PERIPHERAL_IRQ_ENABLE_POS];
                    gie_d = bus.wdata[gtc_pkg::GIE_POS];
                end
                gtc_pkg::ADDR_COUNT_LOW:
                begin
                    count_d = {count_q[15:8], bus.wdata};
                    armed_d = 1'b0;
                end
                gtc_pkg::ADDR_COUNT_HIGH:
                begin
                    count_d = {bus.wdata, count_q[7:0]};
                    armed_d = 1'b0;
                end
                gtc_pkg::ADDR_OPTION:       option_d = bus.wdata;
                default:                    ;
            endcase
        end
        // Hardware set wins over a software clear in the same cycle.
        if (inc && count_q == gtc_pkg::COUNT_MAX)
        begin
            ovf_flag_d = 1'b1;
        end
        if (fall(gval_q, gval_d))
        begin
            gev_flag_d = 1'b1;
        end
        irq_d = (ovf_flag_q && ovf_ie_q && run_q && peripheral_irq_enable_q && gie_q)
             || (gev_flag_q && gev_ie_q && peripheral_irq_enable_q && gie_q);
        wake_d = sleep_mode && ((ovf_flag_q && ovf_ie_q && peripheral_irq_enable_q)
                 || (gev_flag_q && gev_ie_q && peripheral_irq_enable_q));
        vec_d = wake_d && gie_q;
        rdata_d = gtc_pkg::BYTE_ZERO;
        if (bus.rd)
        begin
            case (bus.addr)
                gtc_pkg::ADDR_COUNTER_CTRL:
                begin
                    rdata_d[gtc_pkg::RUN_POS] = run_q;
                    rdata_d[gtc_pkg::SYNCB_POS] = syncb_q;
                end
                gtc_pkg::ADDR_GATE_CTRL:
                begin
                    rdata_d[gtc_pkg::GEN_POS] = gcfg_q.gate_enable_bit;
                    rdata_d[gtc_pkg::GPOL_POS] = gcfg_q.gate_polarity_bit;
                    rdata_d[gtc_pkg::GTM_POS] = gcfg_q.gate_toggle_enable;
                    rdata_d[gtc_pkg::GSPM_POS] = gcfg_q.gate_single_pulse_enable;
                    rdata_d[gtc_pkg::GGO_POS] = gcfg_q.gate_pulse_go_done;
                    rdata_d[gtc_pkg::GVAL_POS] = gval_q;
                    rdata_d[gtc_pkg::GSEL_LO +: 2] = gcfg_q.gate_source_select;
                end
                gtc_pkg::ADDR_IRQ_FLAGS:
                begin
                    rdata_d[gtc_pkg::OVF_POS] = ovf_flag_q;
                    rdata_d[gtc_pkg::GEV_POS] = gev_flag_q;
                end
                gtc_pkg::ADDR_IRQ_ENABLE:
                begin
                    rdata_d[gtc_pkg::OVF_POS] = ovf_ie_q;
                    rdata_d[gtc_pkg::GEV_POS] = gev_ie_q;
                    rdata_d[gtc_pkg::PERIPHERAL_IRQ_ENABLE_POS] = peripheral_irq_enable_q;
                    rdata_d[gtc_pkg::GIE_POS] = gie_q;
                end
                gtc_pkg::ADDR_COUNT_LOW:    rdata_d = count_q[7:0];
                gtc_pkg::ADDR_COUNT_HIGH:   rdata_d = count_q[15:8];
                gtc_pkg::ADDR_OPTION:       rdata_d = option_q;
                gtc_pkg::ADDR_EIGHT_COUNT:  rdata_d = eight_q;
                gtc_pkg::ADDR_PERIOD_COUNT: rdata_d = per_q;
                gtc_pkg::ADDR_PERIOD_LIMIT: rdata_d = limit_q;
                default:                    rdata_d = gtc_pkg::BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gcfg_q <= '{gate_source_select: gtc_pkg::GSRC_PIN, default: 1'b0};
            sp_q <= gtc_pkg::SP_IDLE;
            src_prev_q <= 1'b0;
            tff_q <= 1'b0;
            gval_q <= 1'b0;
            eight_q <= gtc_pkg::BYTE_ZERO;
            eight_pulse_q <= 1'b0;
            per_q <= gtc_pkg::BYTE_ZERO;
            per_pulse_q <= 1'b0;
            limit_q <= gtc_pkg::LIMIT_RST;
            wbase_q <= gtc_pkg::BYTE_ZERO;
            wpre_q <= gtc_pkg::BYTE_ZERO;
            wdog_q <= gtc_pkg::BYTE_ZERO;
            wdog_pulse_q <= 1'b0;
            run_q <= 1'b0;
            syncb_q <= 1'b0;
            option_q <= gtc_pkg::OPTION_RST;
            ovf_ie_q <= 1'b0;
            gev_ie_q <= 1'b0;
            peripheral_irq_enable_q <= 1'b0;
            gie_q <= 1'b0;
            ovf_flag_q <= 1'b0;
            gev_flag_q <= 1'b0;
            count_q <= gtc_pkg::COUNT_ZERO;
            armed_q <= 1'b0;
            clk_prev_q <= 1'b0;
            rdata <= gtc_pkg::BYTE_ZERO;
            irq <= 1'b0;
            wake <= 1'b0;
            vector_req <= 1'b0;
            watchdog_reset <= 1'b0;
        end
        else
        begin
            gcfg_q <= gcfg_d;
            sp_q <= sp_d;
            src_prev_q <= src_act;
            tff_q <= tff_d;
            gval_q <= gval_d;
            eight_q <= eight_d;
            eight_pulse_q <= eight_pulse_d;
            per_q <= per_d;
            per_pulse_q <= per_pulse_d;
            limit_q <= limit_d;
            wbase_q <= wbase_d;
            wpre_q <= wpre_d;
            wdog_q <= wdog_d;
            wdog_pulse_q <= wdog_pulse_d;
            run_q <= run_d;
            syncb_q <= syncb_d;
            option_q <= option_d;
            ovf_ie_q <= ovf_ie_d;
            gev_ie_q <= gev_ie_d;
            peripheral_irq_enable_q <= peripheral_irq_enable_d;
            gie_q <= gie_d;
            ovf_flag_q <= ovf_flag_d;
            gev_flag_q <= gev_flag_d;
            count_q <= count_d;
            armed_q <= armed_d;
            clk_prev_q <= external_count_pin;
            rdata <= rdata_d;
            irq <= irq_d;
            wake <= wake_d;
            vector_req <= vec_d;
            watchdog_reset <= wrst_d;
        end
    end

endmodule

// ===== design/gtc_pkg.sv
package gtc_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_COUNTER_CTRL = 4'h0;
    localparam logic [3:0] ADDR_GATE_CTRL    = 4'h1;
    localparam logic [3:0] ADDR_IRQ_FLAGS    = 4'h2;
    localparam logic [3:0] ADDR_IRQ_ENABLE   = 4'h3;
    localparam logic [3:0] ADDR_COUNT_LOW    = 4'h4;
    localparam logic [3:0] ADDR_COUNT_HIGH   = 4'h5;
    localparam logic [3:0] ADDR_OPTION       = 4'h6;
    localparam logic [3:0] ADDR_EIGHT_COUNT  = 4'h7;
    localparam logic [3:0] ADDR_PERIOD_COUNT = 4'h8;
    localparam logic [3:0] ADDR_PERIOD_LIMIT = 4'h9;

    // Counter control fields.
    localparam int RUN_POS   = 0;
    localparam int SYNCB_POS = 2;
    // Gate control fields.
    localparam int GSEL_LO   = 0;
    localparam int GVAL_POS  = 2;
    localparam int GGO_POS   = 3;
    localparam int GSPM_POS  = 4;
    localparam int GTM_POS   = 5;
    localparam int GPOL_POS  = 6;
    localparam int GEN_POS   = 7;
    // Flag and enable fields.
    localparam int OVF_POS   = 0;
    localparam int GEV_POS   = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_POS  = 6;
    localparam int GIE_POS   = 5;
    // Option fields.
    localparam int PS_LO     = 0;
    localparam int PSA_POS   = 3;

    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    localparam logic [7:0]  BYTE_MAX    = 8'hFF;
    localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO  = 16'h0000;
    localparam logic [7:0]  OPTION_RST  = 8'hFF;
    localparam logic [7:0]  LIMIT_RST   = 8'hFF;
    localparam logic [7:0]  PRESC_ONE   = 8'h01;

    // Watchdog base tick: one per this many clock cycles.
    localparam int          WDT_BASE_NS  = 640;
    localparam int          CLK_NS       = 40;
    localparam logic [7:0]  WDT_BASE_CYC = 8'(WDT_BASE_NS / CLK_NS);

    typedef enum logic [1:0] {
        GSRC_PIN    = 2'b00,
        GSRC_EIGHT  = 2'b01,
        GSRC_PERIOD = 2'b10,
        GSRC_WDOG   = 2'b11
    } gtc_gsrc_type;

    typedef enum logic [1:0] {
        SP_IDLE  = 2'b00,
        SP_ARMED = 2'b01,
        SP_COUNT = 2'b10
    } gtc_sp_type;

    typedef struct packed {
        logic         gate_enable_bit;
        logic         gate_polarity_bit;
        logic         gate_toggle_enable;
        logic         gate_single_pulse_enable;
        logic         gate_pulse_go_done;
        gtc_gsrc_type gate_source_select;
    } gtc_gate_cfg_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } gtc_bus_type;

endpackage

// ===== sim/gtc_gated_timer_props.sv
`timescale 1ns/10ps
module gtc_gated_timer_props (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       watchdog_enable_fuse,
    input wire logic       sleep_mode,
    input wire logic       irq,
    input wire logic       wake,
    input wire logic       vector_req,
    input wire logic       watchdog_reset
);
    logic [7:0] en_q;
    logic [7:0] en_d;

    // Shadow of the enable register, so that outputs can be tied to what software set.
    always_comb en_d = (wr && addr == gtc_pkg::ADDR_IRQ_ENABLE) ? wdata : en_q;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            en_q <= 8'h00;
        else
            en_q <= en_d;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_rd_en;
        rd && addr == gtc_pkg::ADDR_IRQ_ENABLE;
    endsequence
    sequence s_wd_fire;
        watchdog_reset;
    endsequence

    // Either the old or the new enable value may feed a registered output.
    property p_irq_enables;
        irq |-> (en_q[5] && en_q[6]) || ($past(en_q[5]) && $past(en_q[6]));
    endproperty
    property p_wake_sleep;
        wake |-> $past(sleep_mode) || $past(sleep_mode, 2);
    endproperty
    property p_wake_peripheral_irq_enable;
        wake |-> en_q[6] || $past(en_q[6]);
    endproperty
    property p_vector_gie;
        vector_req |-> (wake || $past(wake)) && (en_q[5] || $past(en_q[5]));
    endproperty
    property p_en_readback;
        s_rd_en |=> (rdata & 8'hE1) == ($past(en_q) & 8'hE1);
    endproperty
    property p_wdog_fuse;
        s_wd_fire |-> $past(watchdog_enable_fuse);
    endproperty
    property p_wdog_pulse;
        s_wd_fire |=> !watchdog_reset;
    endproperty
    property p_rdata_idle;
        !rd ##1 !rd |-> rdata == 8'h00;
    endproperty

    a_irq_enables: assert property (p_irq_enables)
        else $error("irq without peripheral and global enables");
    a_wake_sleep: assert property (p_wake_sleep)
        else $error("wake while not asleep");
    a_wake_peripheral_irq_enable: assert property (p_wake_peripheral_irq_enable)
        else $error("wake without peripheral enable");
    a_vector_gie: assert property (p_vector_gie)
        else $error("vector request without wake and global enable");
    a_en_readback: assert property (p_en_readback)
        else $error("enable register read back wrong");
    a_wdog_fuse: assert property (p_wdog_fuse)
        else $error("watchdog reset with watchdog disabled");
    a_wdog_pulse: assert property (p_wdog_pulse)
        else $error("watchdog reset longer than one cycle");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read cycle");
endmodule

// ===== sim/gtc_gated_timer_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module gtc_gated_timer_tb_top;
    localparam logic [3:0] CT = gtc_pkg::ADDR_COUNTER_CTRL;
    localparam logic [3:0] GC = gtc_pkg::ADDR_GATE_CTRL;
    localparam logic [3:0] FL = gtc_pkg::ADDR_IRQ_FLAGS;
    localparam logic [3:0] IE = gtc_pkg::ADDR_IRQ_ENABLE;
    localparam int         LIMIT = 24000;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       sleep_mode = 1'b0;
    logic       tick_en = 1'b0;
    logic       watchdog_enable_fuse = 1'b0;
    logic       watchdog_clear_instr = 1'b0;
    logic [7:0] rdata;
    logic       irq, wake, vector_req, watchdog_reset;
    logic       gate_input, external_count_pin, eight_bit_tick, period_tick;
    int         error_cnt = 0;
    int         checked = 0;
    int         cyc = 0;

    always #20 clk = ~clk;

    gtc_gated_timer i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .gate_input(gate_input),
        .external_count_pin(external_count_pin), .eight_bit_tick(eight_bit_tick),
        .period_tick(period_tick), .watchdog_enable_fuse(watchdog_enable_fuse),
        .watchdog_clear_instr(watchdog_clear_instr), .sleep_mode(sleep_mode), .irq(irq),
        .wake(wake),
        .vector_req(vector_req), .watchdog_reset(watchdog_reset));

    gtc_src_model i_src (.clk(clk), .tick_en(tick_en), .gate_input(gate_input),
        .external_count_pin(external_count_pin), .eight_bit_tick(eight_bit_tick),
        .period_tick(period_tick));

    task automatic end_sim;
        if (error_cnt == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        `CHK(d & m, e)
    endtask

    task automatic get_cnt(output logic [15:0] c);
        rd_reg(gtc_pkg::ADDR_COUNT_LOW, c[7:0]);
        rd_reg(gtc_pkg::ADDR_COUNT_HIGH, c[15:8]);
    endtask

    // Three count pulses, then the change of the counter is compared.
    task automatic meas(input logic [15:0] e);
        logic [15:0] c0;
        logic [15:0] c1;
        get_cnt(c0);
        i_src.pulses(3);
        get_cnt(c1);
        `CHK(c1 - c0, e)
    endtask

    task automatic t_reset;
        for (int i = 0; i < 16; i++)
            chk_reg(4'(i), (i == 1) ? 8'hFB : 8'hFF, (i == 6 || i == 9) ? 8'hFF : 8'h00);
    endtask

    task automatic t_run_gate;
        meas(16'h0000);
        wr_reg(CT, 8'h01);
        i_src.pulses(1);
        for (int k = 0; k < 8; k++)
        begin
            wr_reg(GC, {k[2], k[1], 6'h00});
            i_src.set_gate(k[0]);
            chk_reg(GC, 8'h04, {5'h00, k[0] == k[1], 2'h0});
            meas((!k[2] || k[0] == k[1]) ? 16'h0003 : 16'h0000);
        end
    endtask

    task automatic t_event;
        wr_reg(GC, 8'h40);
        wr_reg(FL, 8'h00);
        i_src.set_gate(1'b0);
        chk_reg(FL, 8'h80, 8'h80);
        wr_reg(IE, 8'hE0);
        repeat (3) @(negedge clk);
        `CHK(irq, 1'b1)
        wr_reg(FL, 8'h00);
        repeat (3) @(negedge clk);
        `CHK(irq, 1'b0)
    endtask

    // The pin source stays low here, so only the internal sources may raise the flag.
    task automatic t_sources;
        wr_reg(gtc_pkg::ADDR_PERIOD_LIMIT, 8'h03);
        for (int s = 0; s < 3; s++)
        begin
            wr_reg(GC, 8'h40 | 8'(s));
            wr_reg(FL, 8'h00);
            tick_en <= 1'b1;
            repeat (600) @(posedge clk);
            tick_en <= 1'b0;
            repeat (4) @(posedge clk);
            chk_reg(FL, 8'h80, (s != 0) ? 8'h80 : 8'h00);
        end
    endtask

    task automatic t_toggle;
        wr_reg(GC, 8'hE0);
        meas(16'h0000);
        i_src.set_gate(1'b1);
        meas(16'h0003);
        i_src.set_gate(1'b0);
        meas(16'h0003);
        wr_reg(GC, 8'hC0);
        wr_reg(GC, 8'hE0);
        meas(16'h0000);
    endtask

    task automatic t_single;
        wr_reg(GC, 8'hD0);
        wr_reg(GC, 8'hD8);
        chk_reg(GC, 8'h08, 8'h08);
        i_src.set_gate(1'b1);
        meas(16'h0003);
        i_src.set_gate(1'b0);
        chk_reg(GC, 8'h08, 8'h00);
        i_src.set_gate(1'b1);
        meas(16'h0000);
        i_src.set_gate(1'b0);
        wr_reg(GC, 8'hD8);
        wr_reg(GC, 8'hC8);
        chk_reg(GC, 8'h08, 8'h00);
        wr_reg(GC, 8'hF0);
        wr_reg(GC, 8'hF8);
        i_src.set_gate(1'b1);
        meas(16'h0003);
        i_src.set_gate(1'b0);
        chk_reg(GC, 8'h08, 8'h08);
        i_src.set_gate(1'b1);
        chk_reg(GC, 8'h08, 8'h00);
    endtask

    task automatic t_ovf;
        logic [15:0] c;
        wr_reg(GC, 8'h00);
        wr_reg(CT, 8'h00);
        wr_reg(FL, 8'h00);
        wr_reg(gtc_pkg::ADDR_COUNT_HIGH, 8'hFF);
        wr_reg(gtc_pkg::ADDR_COUNT_LOW, 8'hFD);
        wr_reg(IE, 8'h61);
        sleep_mode <= 1'b1;
        wr_reg(CT, 8'h05);
        i_src.pulses(1);
        get_cnt(c);
        `CHK(c, 16'hFFFD)
        i_src.pulses(3);
        get_cnt(c);
        `CHK(c, 16'h0000)
        chk_reg(FL, 8'h01, 8'h01);
        `CHK(irq, 1'b1)
        `CHK(wake, 1'b1)
        `CHK(vector_req, 1'b1)
        wr_reg(CT, 8'h01);
        meas(16'h0000);
        sleep_mode <= 1'b0;
        wr_reg(CT, 8'h04);
        repeat (3) @(negedge clk);
        `CHK(irq, 1'b0)
    endtask

    // The watchdog pulse lasts one cycle, so its gate is always measured through toggle mode.
    task automatic t_wdog;
        int hits;
        hits = 0;
        wr_reg(gtc_pkg::ADDR_OPTION, 8'h00);
        wr_reg(GC, 8'hE3);
        wr_reg(FL, 8'h00);
        repeat (6000) @(posedge clk);
        chk_reg(FL, 8'h80, 8'h00);
        repeat (3000) @(posedge clk);
        chk_reg(FL, 8'h80, 8'h80);
        @(posedge clk);
        watchdog_enable_fuse <= 1'b1;
        watchdog_clear_instr <= 1'b1;
        @(posedge clk);
        watchdog_clear_instr <= 1'b0;
        repeat (4200)
        begin
            @(negedge clk);
            hits += int'(watchdog_reset);
        end
        `CHK(hits, 1)
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_run_gate();
        t_event();
        t_sources();
        t_toggle();
        t_single();
        t_ovf();
        t_wdog();
        end_sim();
    end
endmodule

bind gtc_gated_timer gtc_gated_timer_props i_props (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .watchdog_enable_fuse(watchdog_enable_fuse), .sleep_mode(sleep_mode), .irq(irq),
    .wake(wake), .vector_req(vector_req), .watchdog_reset(watchdog_reset));

// ===== sim/gtc_src_model.sv
`timescale 1ns/10ps
module gtc_src_model (
    input  wire logic clk,
    input  wire logic tick_en,
    output logic      gate_input,
    output logic      external_count_pin,
    output logic      eight_bit_tick,
    output logic      period_tick
);
    initial
    begin
        gate_input = 1'b0;
        external_count_pin = 1'b0;
        eight_bit_tick = 1'b0;
        period_tick = 1'b0;
    end

    always @(posedge clk)
    begin
        eight_bit_tick <= tick_en;
        period_tick <= tick_en;
    end

    // The gate value lags the pin, so each change is given time to settle.
    task automatic set_gate(input logic v);
        @(posedge clk);
        gate_input <= v;
        repeat (4) @(posedge clk);
    endtask

    // The count pin idles low between bursts, like a stopped external clock.
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clk);
            external_count_pin <= 1'b1;
            repeat (2) @(posedge clk);
            external_count_pin <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (2) @(posedge clk);
    endtask
endmodule
